// *** pifb_evt_model.sv ***
/*
 * Model of the peripheral and core event sources of the flag bank.
 * Assumes the bench asks for one burst at a time on ref_clk_i.
 */
`timescale 1ns/1ps
module pifb_evt_model (
  input wire logic ref_clk_i,
  input wire logic fire_i,
  input wire logic [1:0] grp_i,
  input wire pifb_pkg::pifb_byte_t bits_i,
  output pifb_pkg::pifb_byte_t evt_a_o,
  output pifb_pkg::pifb_byte_t evt_b_o,
  output pifb_pkg::pifb_byte_t evt_c_o,
  output logic [pifb_pkg::CORE_SRC_N-1:0] core_evt_o
);
  import pifb_pkg::*;
  // A source raises its event for one cycle and then drops it again.
  always_ff @(posedge ref_clk_i) begin
    evt_a_o <= (fire_i && grp_i == 2'h0) ? bits_i : 8'h00;
    evt_b_o <= (fire_i && grp_i == 2'h1) ? bits_i : 8'h00;
    evt_c_o <= (fire_i && grp_i == 2'h2) ? bits_i : 8'h00;
    core_evt_o <= (fire_i && grp_i == 2'h3) ? bits_i[CORE_SRC_N-1:0] : 3'h0;
  end
endmodule

// *** pifb_flag_if.sv ***
/*
 * Link between the top and one request flag register.
 * Assumes the top drives write and event and reads the flags back.
 */
`timescale 1ns/1ps
interface pifb_flag_if;
  import pifb_pkg::*;
  logic wr;
  pifb_byte_t wdata;
  pifb_byte_t evt;
  pifb_byte_t flags;
  modport owner (input wr, input wdata, input evt, output flags);
  modport user (output wr, output wdata, output evt, input flags);
endinterface

// *** pifb_flag_reg.sv ***
/*
 * One request flag register with hardware set and software write.
 * Assumes event bits are one-cycle or level requests synchronous to the clock.
 */
`timescale 1ns/1ps
module pifb_flag_reg #(
  parameter pifb_pkg::pifb_byte_t IMPL = 8'hff
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  pifb_flag_if.owner fl
);
  import pifb_pkg::*;

  pifb_byte_t flag_reg;
  pifb_byte_t flag_next;
  pifb_byte_t kept;

  // An event in the cycle of a write still sets its flag.
  assign kept = fl.wr ? fl.wdata : flag_reg;
  assign flag_next = (kept | fl.evt) & IMPL;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_reg <= RST_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign fl.flags = flag_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_evt_sets_flag: assert property (
    |(fl.evt & IMPL) |=> ((flag_reg & $past(fl.evt & IMPL)) == $past(fl.evt & IMPL)))
    else $error("event did not set its flag");

  chk_unimpl_zero: assert property (
    (flag_reg & ~IMPL) == RST_VAL)
    else $error("unimplemented flag bit is set");

  chk_write_loads: assert property (
    (fl.wr && fl.evt == RST_VAL) |=> flag_reg == $past(fl.wdata & IMPL))
    else $error("flag write not stored");

  chk_reset_clears: assert property (
    @(posedge ref_clk_i) disable iff (1'b0) rst_i |=> flag_reg == RST_VAL)
    else $error("flag not cleared by reset");

endmodule

// *** pifb_pkg.sv ***
/*
 * Constants, types and register map of the peripheral interrupt flag bank.
 * Assumes one 25 MHz clock, a synchronous active-high reset and a plain
 * strobe register port with read data one cycle after the read strobe.
 */
// Summary of operation
// - A source event sets its request flag whatever its enable and the global enable hold.
// - Flags b holds oscillator fail at 7, comparator 2 at 6, comparator 1 at 5, collision at 3
//       and numeric oscillator at 2.
// - Flags c bits 3 down to 0 hold logic cells 4, 3, 2 and 1.
// - A flag reading 1 means pending and 0 means not pending.
// - Bits 4 and 1-0 of flags b and bits 7-4 of flags c read as zero.
// - Every implemented flag is read/write and clears to zero on every reset.
// - Core control holds global enable at 7, group enable at 6, enables 5-3 and flags 2-0.
// - Each enable register uses the bit positions of its flag register, unused bits read zero.
// - No peripheral interrupt reaches the core unless the group enable is set.
// - An enable bit at 1 lets its source interrupt and at 0 blocks it.
package pifb_pkg;

  typedef logic [7:0] pifb_byte_t;
  typedef logic [3:0] pifb_off_t;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam int OFF_W = 4;
  localparam pifb_off_t OFF_CORE = 4'h0;
  localparam pifb_off_t OFF_PIE_A = 4'h1;
  localparam pifb_off_t OFF_PIE_B = 4'h2;
  localparam pifb_off_t OFF_PIE_C = 4'h3;
  localparam pifb_off_t OFF_PIR_A = 4'h4;
  localparam pifb_off_t OFF_PIR_B = 4'h5;
  localparam pifb_off_t OFF_PIR_C = 4'h6;
  localparam pifb_off_t OFF_EVT_ST = 4'h7;
  localparam pifb_off_t OFF_EVT_MASK = 4'h8;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GIE_BIT = 7;
  localparam int PERIPH_GROUP_EN_BIT = 6;
  localparam int CORE_EN_LSB = 3;
  localparam int CORE_FLAG_LSB = 0;
  localparam int CORE_SRC_N = 3;
  localparam int OSC_FAIL_BIT = 7;
  localparam int CMP_TWO_BIT = 6;
  localparam int CMP_ONE_BIT = 5;
  localparam int COLLISION_BIT = 3;
  localparam int NUM_OSC_BIT = 2;
  localparam int ST_PERI_BIT = 0;
  localparam int ST_CORE_BIT = 1;
  localparam int ST_IRQ_BIT = 2;

  // ****************************************
  // Implemented bits and reset values
  // ****************************************
  localparam pifb_byte_t PIR_A_IMPL = 8'hfb;
  localparam pifb_byte_t PIR_B_IMPL = 8'((1 << OSC_FAIL_BIT) | (1 << CMP_TWO_BIT)
    | (1 << CMP_ONE_BIT) | (1 << COLLISION_BIT) | (1 << NUM_OSC_BIT));
  localparam pifb_byte_t PIR_C_IMPL = 8'h0f;
  localparam pifb_byte_t CORE_FLAG_IMPL = 8'h07;
  localparam pifb_byte_t CORE_EN_IMPL = 8'hf8;
  localparam pifb_byte_t ST_IMPL = 8'h07;
  localparam pifb_byte_t RST_VAL = 8'h00;

  localparam int PIE_N = 3;
  localparam int FLAG_N = 4;
  localparam int CORE_IDX = 3;
  localparam pifb_byte_t FLAG_IMPL [FLAG_N] = '{PIR_A_IMPL, PIR_B_IMPL, PIR_C_IMPL,
    CORE_FLAG_IMPL};
  localparam pifb_off_t FLAG_OFF [FLAG_N] = '{OFF_PIR_A, OFF_PIR_B, OFF_PIR_C, OFF_CORE};
  localparam pifb_off_t PIE_OFF [PIE_N] = '{OFF_PIE_A, OFF_PIE_B, OFF_PIE_C};

endpackage

// *** pifb_tb.sv ***
/*
 * Self-checking bench of the peripheral interrupt flag bank.
 * Assumes the strobe register port and the event model beside it.
 */
`timescale 1ns/1ps
module testbench;
  import pifb_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  pifb_byte_t wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  pifb_byte_t rdata_o, ea, eb, ec;
  logic [CORE_SRC_N-1:0] ce;
  logic core_irq_o, sys_irq_o;
  logic fire = 1'b0;
  logic [1:0] grp = 2'h0;
  pifb_byte_t bits = 8'h00;
  int mismatches = 0;
  int n_checks = 0;

  pifb_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .periph_evt_a_i(ea), .periph_evt_b_i(eb),
    .periph_evt_c_i(ec), .core_evt_i(ce), .core_irq_o(core_irq_o), .sys_irq_o(sys_irq_o));
  pifb_evt_model src (.ref_clk_i(ref_clk_i), .fire_i(fire), .grp_i(grp), .bits_i(bits),
    .evt_a_o(ea), .evt_b_o(eb), .evt_c_o(ec), .core_evt_o(ce));

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************
  // Bus, event and compare tasks
  // ****************************************
  task automatic chk_byte(input string nm, input pifb_byte_t exp, input pifb_byte_t got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic wr(input pifb_off_t o, input pifb_byte_t d);
    @(posedge ref_clk_i);
    addr_i <= o;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input pifb_off_t o, input pifb_byte_t exp);
    @(posedge ref_clk_i);
    addr_i <= o;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk_byte($sformatf("reg %h", o), exp, rdata_o);
  endtask

  task automatic pulse(input logic [1:0] g, input pifb_byte_t b);
    @(posedge ref_clk_i);
    fire <= 1'b1;
    grp <= g;
    bits <= b;
    @(posedge ref_clk_i);
    fire <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int o = 0; o < 9; o++) rd_chk(pifb_off_t'(o), 8'h00);
    rd_chk(4'hf, 8'h00);
    @(negedge ref_clk_i);
    chk_byte("rdata idle", 8'h00, rdata_o);
    $display("test reset done");
  endtask

  task automatic t_access();
    pifb_off_t offs [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
    pifb_byte_t impl [6] = '{8'hfb, 8'hec, 8'h0f, 8'hfb, 8'hec, 8'h0f};
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], 8'hff);
      rd_chk(offs[i], impl[i]);
      wr(offs[i], 8'h00);
      rd_chk(offs[i], 8'h00);
    end
    wr(OFF_CORE, 8'hf8);
    rd_chk(OFF_CORE, 8'hf8);
    wr(OFF_CORE, 8'h00);
    $display("test access done");
  endtask

  task automatic t_flags();
    pulse(2'h0, 8'hff);
    pulse(2'h1, 8'hff);
    pulse(2'h2, 8'hff);
    pulse(2'h3, 8'h07);
    settle();
    chk_bit("core irq", 1'b0, core_irq_o);
    rd_chk(OFF_PIR_A, 8'hfb);
    rd_chk(OFF_PIR_B, 8'hec);
    rd_chk(OFF_PIR_C, 8'h0f);
    rd_chk(OFF_CORE, 8'h07);
    for (int o = 4; o < 7; o++) wr(pifb_off_t'(o), 8'h00);
    wr(OFF_CORE, 8'h00);
    rd_chk(OFF_PIR_B, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_gate();
    pifb_byte_t pos [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04};
    for (int i = 0; i < 5; i++) begin
      wr(OFF_PIR_B, 8'h00);
      wr(OFF_PIE_B, pos[i]);
      wr(OFF_CORE, 8'hc0);
      pulse(2'h1, pos[i]);
      settle();
      chk_bit("core irq on", 1'b1, core_irq_o);
      wr(OFF_PIE_B, 8'h00);
      settle();
      chk_bit("core irq blocked", 1'b0, core_irq_o);
    end
    wr(OFF_PIR_A, 8'h00);
    wr(OFF_PIE_A, 8'h01);
    pulse(2'h0, 8'h01);
    settle();
    chk_bit("core irq group a", 1'b1, core_irq_o);
    wr(OFF_PIR_A, 8'h00);
    wr(OFF_PIE_A, 8'h00);
    wr(OFF_PIR_B, 8'h00);
    wr(OFF_CORE, 8'h80);
    wr(OFF_PIE_C, 8'h01);
    pulse(2'h2, 8'h01);
    rd_chk(OFF_PIR_C, 8'h01);
    settle();
    chk_bit("core irq no group", 1'b0, core_irq_o);
    wr(OFF_CORE, 8'hc0);
    settle();
    chk_bit("core irq group", 1'b1, core_irq_o);
    wr(OFF_CORE, 8'h40);
    settle();
    chk_bit("core irq no global", 1'b0, core_irq_o);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CORE, 8'h80 | (8'h08 << ((i + 1) % 3)));
      pulse(2'h3, 8'h01 << i);
      settle();
      chk_bit("core irq other en", 1'b0, core_irq_o);
      wr(OFF_CORE, 8'h80 | (8'h08 << i) | (8'h01 << i));
      settle();
      chk_bit("core irq core src", 1'b1, core_irq_o);
      wr(OFF_CORE, 8'h00);
    end
    wr(OFF_PIR_C, 8'h00);
    wr(OFF_PIE_C, 8'h00);
    $display("test gate done");
  endtask

  task automatic t_status();
    wr(OFF_EVT_MASK, 8'h01);
    rd_chk(OFF_EVT_MASK, 8'h01);
    rd_chk(OFF_EVT_ST, 8'h07);
    pulse(2'h1, 8'h80);
    settle();
    chk_bit("sys irq set", 1'b1, sys_irq_o);
    rd_chk(OFF_EVT_ST, 8'h01);
    settle();
    chk_bit("sys irq cleared", 1'b0, sys_irq_o);
    pulse(2'h3, 8'h01);
    settle();
    chk_bit("sys irq masked", 1'b0, sys_irq_o);
    rd_chk(OFF_EVT_ST, 8'h02);
    wr(OFF_EVT_MASK, 8'h04);
    wr(OFF_CORE, 8'h89);
    settle();
    chk_bit("sys irq rise", 1'b1, sys_irq_o);
    wr(OFF_CORE, 8'h00);
    rd_chk(OFF_EVT_ST, 8'h04);
    $display("test status done");
  endtask

  task automatic t_rerst();
    wr(OFF_PIE_A, 8'hff);
    pulse(2'h0, 8'hff);
    settle();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk(OFF_PIE_A, 8'h00);
    rd_chk(OFF_PIR_A, 8'h00);
    rd_chk(OFF_EVT_MASK, 8'h00);
    $display("test second reset done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_access();
    t_flags();
    t_gate();
    t_status();
    t_rerst();
    end_of_test();
  end
endmodule

// *** pifb_top.sv ***
/*
 * Peripheral interrupt flag bank: request flags, enables, core request
 * and a sticky event status with its own interrupt line.
 * Assumes a register master that issues one-cycle strobes, never both at
 * once, and event sources synchronous to ref_clk_i.
 */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pifb_top #(
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire pifb_pkg::pifb_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output pifb_pkg::pifb_byte_t rdata_o,
  input wire pifb_pkg::pifb_byte_t periph_evt_a_i,
  input wire pifb_pkg::pifb_byte_t periph_evt_b_i,
  input wire pifb_pkg::pifb_byte_t periph_evt_c_i,
  input wire logic [pifb_pkg::CORE_SRC_N-1:0] core_evt_i,
  output logic core_irq_o,
  output logic sys_irq_o
);
  import pifb_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (ADDR_W < OFF_W) begin : g_bad_addr
      $error("ADDR_W too narrow for the register map");
    end
  endgenerate

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] a,
    input pifb_off_t off
  );
    return a == ADDR_W'(off);
  endfunction

  logic [FLAG_N-1:0] flag_wr;
  logic [PIE_N-1:0] pie_wr;
  logic core_wr;
  logic mask_wr;
  logic status_rd;

  assign core_wr = wr_i & reg_hit(addr_i, OFF_CORE);
  assign mask_wr = wr_i & reg_hit(addr_i, OFF_EVT_MASK);
  assign status_rd = rd_i & reg_hit(addr_i, OFF_EVT_ST);

  // ****************************************
  // Request flag registers
  // ****************************************
  pifb_byte_t evt_in [FLAG_N];
  pifb_byte_t flag_val [FLAG_N];

  assign evt_in[0] = periph_evt_a_i;
  assign evt_in[1] = periph_evt_b_i;
  assign evt_in[2] = periph_evt_c_i;
  assign evt_in[CORE_IDX] = pifb_byte_t'(core_evt_i) << CORE_FLAG_LSB;

  pifb_flag_if fl [FLAG_N] ();

  generate
    for (genvar g = 0; g < FLAG_N; g++) begin : g_flag
      assign flag_wr[g] = wr_i & reg_hit(addr_i, FLAG_OFF[g]);
      assign fl[g].wr = flag_wr[g];
      assign fl[g].wdata = wdata_i;
      assign fl[g].evt = evt_in[g];
      assign flag_val[g] = fl[g].flags;

      pifb_flag_reg #(
        .IMPL(FLAG_IMPL[g])
      ) u_bank (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .fl(fl[g])
      );
    end
  endgenerate

  // ****************************************
  // Enable registers
  // ****************************************
  pifb_byte_t pie_reg [PIE_N];
  pifb_byte_t pie_next [PIE_N];
  logic [PIE_N-1:0] pie_hit;

  generate
    for (genvar g = 0; g < PIE_N; g++) begin : g_pie
      assign pie_wr[g] = wr_i & reg_hit(addr_i, PIE_OFF[g]);
      // Enables share the flag layout, so the flag mask applies.
      assign pie_next[g] = pie_wr[g] ? (wdata_i & FLAG_IMPL[g]) : pie_reg[g];
      assign pie_hit[g] = |(flag_val[g] & pie_reg[g]);

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          pie_reg[g] <= RST_VAL;
        end else begin
          pie_reg[g] <= pie_next[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Core control enables
  // ****************************************
  pifb_byte_t core_en_reg;
  pifb_byte_t core_en_next;
  pifb_byte_t core_view;
  logic global_irq_en;
  logic periph_group_en;

  assign core_en_next = core_wr ? (wdata_i & CORE_EN_IMPL) : core_en_reg;
  assign global_irq_en = core_en_reg[GIE_BIT];
  assign periph_group_en = core_en_reg[PERIPH_GROUP_EN_BIT];
  // Enables sit in the upper bits, flags in the lower ones.
  assign core_view = core_en_reg | flag_val[CORE_IDX];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      core_en_reg <= RST_VAL;
    end else begin
      core_en_reg <= core_en_next;
    end
  end

  // ****************************************
  // Core interrupt request
  // ****************************************
  logic core_pend;
  logic periph_pend;
  logic core_irq_reg;
  logic core_irq_next;

  assign core_pend = |(flag_val[CORE_IDX][CORE_FLAG_LSB +: CORE_SRC_N]
    & core_en_reg[CORE_EN_LSB +: CORE_SRC_N]);
  assign periph_pend = periph_group_en & (|pie_hit);
  assign core_irq_next = global_irq_en & (core_pend | periph_pend);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      core_irq_reg <= 1'b0;
    end else begin
      core_irq_reg <= core_irq_next;
    end
  end

  assign core_irq_o = core_irq_reg;

  // ****************************************
  // Event status and its interrupt
  // ****************************************
  pifb_byte_t evt_status_reg;
  pifb_byte_t evt_status_next;
  pifb_byte_t evt_mask_reg;
  pifb_byte_t evt_mask_next;
  pifb_byte_t status_set;
  logic peri_evt;
  logic core_evt;
  logic irq_rise;
  logic sys_irq_reg;
  logic sys_irq_next;

  assign peri_evt = |(periph_evt_a_i & PIR_A_IMPL) | |(periph_evt_b_i & PIR_B_IMPL)
    | |(periph_evt_c_i & PIR_C_IMPL);
  assign core_evt = |core_evt_i;
  assign irq_rise = core_irq_next & ~core_irq_reg;
  assign status_set = (pifb_byte_t'(peri_evt) << ST_PERI_BIT)
    | (pifb_byte_t'(core_evt) << ST_CORE_BIT)
    | (pifb_byte_t'(irq_rise) << ST_IRQ_BIT);
  // A read clears the status, but an event in the same cycle survives.
  assign evt_status_next = ((status_rd ? RST_VAL : evt_status_reg) | status_set) & ST_IMPL;
  assign evt_mask_next = mask_wr ? (wdata_i & ST_IMPL) : evt_mask_reg;
  assign sys_irq_next = |(evt_status_next & evt_mask_next);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      evt_status_reg <= RST_VAL;
      evt_mask_reg <= RST_VAL;
      sys_irq_reg <= 1'b0;
    end else begin
      evt_status_reg <= evt_status_next;
      evt_mask_reg <= evt_mask_next;
      sys_irq_reg <= sys_irq_next;
    end
  end

  assign sys_irq_o = sys_irq_reg;

  // ****************************************
  // Read path
  // ****************************************
  pifb_byte_t rd_val;
  pifb_byte_t rdata_reg;
  pifb_byte_t rdata_next;

  // Unmapped offsets read as zero.
  assign rd_val =
    reg_hit(addr_i, OFF_CORE) ? core_view :
    reg_hit(addr_i, OFF_PIE_A) ? pie_reg[0] :
    reg_hit(addr_i, OFF_PIE_B) ? pie_reg[1] :
    reg_hit(addr_i, OFF_PIE_C) ? pie_reg[2] :
    reg_hit(addr_i, OFF_PIR_A) ? flag_val[0] :
    reg_hit(addr_i, OFF_PIR_B) ? flag_val[1] :
    reg_hit(addr_i, OFF_PIR_C) ? flag_val[2] :
    reg_hit(addr_i, OFF_EVT_ST) ? evt_status_reg :
    reg_hit(addr_i, OFF_EVT_MASK) ? evt_mask_reg :
    RST_VAL;
  assign rdata_next = rd_i ? rd_val : RST_VAL;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_reg <= RST_VAL;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cell_one_evt;
    periph_evt_c_i[0] && !wr_i;
  endsequence

  sequence s_read_flags_c;
    rd_i && reg_hit(addr_i, OFF_PIR_C);
  endsequence

  chk_gie_blocks_irq: assert property (
    !global_irq_en |=> !core_irq_o)
    else $error("core request without global enable");

  chk_periph_group_en_gates_group: assert property (
    (!periph_group_en && !core_pend) |=> !core_irq_o)
    else $error("peripheral request passed a clear group enable");

  chk_enabled_raises: assert property (
    (global_irq_en && periph_group_en && |(flag_val[2] & pie_reg[2])) |=> core_irq_o)
    else $error("enabled pending flag did not raise the core request");

  chk_enable_blocks: assert property (
    (!core_pend && pie_hit == '0) |=> !core_irq_o)
    else $error("core request with no enabled pending flag");

  chk_pending_reads_one: assert property (
    s_cell_one_evt ##1 s_read_flags_c |=> rdata_o[0])
    else $error("pending flag did not read as one");

  chk_flags_b_layout: assert property (
    (rd_i && reg_hit(addr_i, OFF_PIR_B)) |=>
      rdata_o == $past(flag_val[1]) && (rdata_o & ~PIR_B_IMPL) == RST_VAL)
    else $error("flags b read wrong");

  chk_flags_c_layout: assert property (
    (rd_i && reg_hit(addr_i, OFF_PIR_C)) |=>
      (rdata_o & ~PIR_C_IMPL) == RST_VAL)
    else $error("flags c upper bits not zero");

  chk_core_layout: assert property (
    (rd_i && reg_hit(addr_i, OFF_CORE)) |=>
      rdata_o[GIE_BIT] == $past(global_irq_en) && rdata_o[PERIPH_GROUP_EN_BIT] == $past(periph_group_en))
    else $error("core control enables misplaced");

  chk_enable_same_pos: assert property (
    pie_wr[1] |=> pie_reg[1] == $past(wdata_i & PIR_B_IMPL))
    else $error("enable b not stored at flag positions");

  chk_status_read_clears: assert property (
    (status_rd && status_set == RST_VAL) |=> evt_status_reg == RST_VAL)
    else $error("status not cleared by read");

  chk_rdata_one_cycle: assert property (
    !rd_i |=> rdata_o == RST_VAL)
    else $error("read data held beyond its cycle");

  sequence s_b_evt_armed;
    global_irq_en && periph_group_en && |(periph_evt_b_i & pie_reg[1]) && !wr_i;
  endsequence

  chk_event_to_irq: assert property (
    s_b_evt_armed |=> ##1 core_irq_o)
    else $error("enabled event did not reach the core request");

  chk_core_src_raises: assert property (
    (global_irq_en && core_pend) |=> core_irq_o)
    else $error("enabled core flag did not raise the core request");

  chk_core_en_write: assert property (
    core_wr |=> core_en_reg == $past(wdata_i & CORE_EN_IMPL))
    else $error("core control enables not stored");

  chk_enable_c_pos: assert property (
    pie_wr[2] |=> pie_reg[2] == $past(wdata_i & PIR_C_IMPL))
    else $error("enable c not stored at flag positions");

  chk_enable_a_pos: assert property (
    pie_wr[0] |=> pie_reg[0] == $past(wdata_i & PIR_A_IMPL))
    else $error("enable a not stored at flag positions");

  chk_unmapped_zero: assert property (
    (rd_i && addr_i > ADDR_W'(OFF_EVT_MASK)) |=> rdata_o == RST_VAL)
    else $error("unmapped offset read not zero");

  chk_status_peri: assert property (
    peri_evt |=> evt_status_reg[ST_PERI_BIT])
    else $error("peripheral event not recorded in status");

  chk_status_core: assert property (
    core_evt |=> evt_status_reg[ST_CORE_BIT])
    else $error("core event not recorded in status");

  chk_status_rise: assert property (
    irq_rise |=> evt_status_reg[ST_IRQ_BIT])
    else $error("core request rise not recorded in status");

  chk_status_sticky: assert property (
    (!status_rd && status_set == RST_VAL) |=> $stable(evt_status_reg))
    else $error("status changed without an event or a read");

  chk_mask_write: assert property (
    mask_wr |=> evt_mask_reg == $past(wdata_i & ST_IMPL))
    else $error("event mask not stored");

  chk_sys_irq_level: assert property (
    sys_irq_o == |(evt_status_reg & evt_mask_reg))
    else $error("system interrupt does not follow status and mask");

endmodule
